/* File: verilog/dpd_deep_power_down_control.sv */
`default_nettype none
module dpd_deep_power_down_control #(
	parameter bit LOW_VOLTAGE = 1'b1,
	parameter int RESET_CYC = dpd_pkg::POWER_UP_SELECT_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic opInProgress,
	output logic cmdAccept,
	output logic featureReset,
	output dpd_pkg::dpd_status_s status
);
	import dpd_pkg::*;

	logic [1:0] csSync_q;
	logic [1:0] clkSync_q;
	logic [1:0] dinSync_q;
	logic csPrev_q;
	logic clkPrev_q;
	logic [7:0] shift_q;
	logic [3:0] bitCnt_q;
	logic resetArmed_q;
	dpd_state_e state_q;
	logic [CNT_W-1:0] timer_q;
	logic csRise;
	logic clkRise;
	logic frameOk;
	logic [7:0] opcode;
	logic sleepGo;
	logic wakeGo;
	logic wakeByReset;

	function automatic logic wakeCmd(input logic [7:0] op, input logic armed);
		wakeCmd = (op == CMD_RELEASE) || (op == CMD_SOFT_RESET) || (armed && op == CMD_RESET);
	endfunction

	// shared by every delay state, so the end point is the same for all of them
	function automatic logic timerDone(input logic [CNT_W-1:0] t);
		timerDone = (t <= CNT_W'(1));
	endfunction

	// two flops per pin; only the second stage feeds logic
	// edge history resets to the idle pin level, so reset gives no false edge
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			csSync_q <= 2'h3;
			csPrev_q <= 1'b1;
		end else begin
			csSync_q <= {csSync_q[0], csN};
			csPrev_q <= csSync_q[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			clkSync_q <= 2'h0;
			clkPrev_q <= 1'b0;
		end else begin
			clkSync_q <= {clkSync_q[0], sclk};
			clkPrev_q <= clkSync_q[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dinSync_q <= 2'h0;
		end else begin
			dinSync_q <= {dinSync_q[0], mosi};
		end
	end

	assign csRise = csSync_q[1] && !csPrev_q;
	assign clkRise = clkSync_q[1] && !clkPrev_q && !csSync_q[1];
	// exactly eight bits latched when chip select rises
	assign frameOk = csRise && (bitCnt_q == 4'h8);
	assign opcode = shift_q;
	// a busy array blocks both entry and wake, leaving the running cycle alone
	assign sleepGo = frameOk && (opcode == CMD_SLEEP) && LOW_VOLTAGE && !opInProgress;
	assign wakeGo = frameOk && wakeCmd(opcode, resetArmed_q) && !opInProgress;
	assign wakeByReset = wakeGo && (opcode == CMD_RESET);

	always_ff @(posedge clk_sys) begin
		if (srst || csSync_q[1]) begin
			bitCnt_q <= 4'h0;
		end else if (clkRise && bitCnt_q != 4'h9) begin
			// saturate so longer frames never look like eight bits
			bitCnt_q <= bitCnt_q + 4'h1;
		end
	end

	// no reset needed: the opcode is only read together with a full frame
	always_ff @(posedge clk_sys) begin
		if (clkRise) begin
			shift_q <= {shift_q[6:0], dinSync_q[1]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			resetArmed_q <= 1'b0;
		end else if (frameOk) begin
			resetArmed_q <= (opcode == CMD_RESET_ENABLE);
		end else if (csRise) begin
			resetArmed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= DPD_STANDBY;
		end else begin
			case (state_q)
				DPD_STANDBY: begin
					// a bare deselect never reaches sleep; only the command does
					if (sleepGo) begin
						state_q <= DPD_ENTERING;
					end
					// release here falls through untouched
				end
				DPD_ENTERING: begin
					if (timerDone(timer_q)) begin
						state_q <= DPD_SLEEP;
					end
				end
				DPD_SLEEP: begin
					if (wakeByReset) begin
						state_q <= DPD_RESETTING;
					end else if (wakeGo) begin
						state_q <= DPD_EXITING;
					end
				end
				DPD_EXITING: begin
					// host holds chip select high meanwhile
					if (timerDone(timer_q)) begin
						state_q <= DPD_STANDBY;
					end
				end
				DPD_RESETTING: begin
					if (timerDone(timer_q)) begin
						state_q <= DPD_STANDBY;
					end
				end
				default: begin
					state_q <= DPD_STANDBY;
				end
			endcase
		end
	end

	// one down-counter serves entry, exit and reset delays; only one runs at a time
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer_q <= '0;
		end else begin
			case (state_q)
				DPD_STANDBY: begin
					if (sleepGo) begin
						timer_q <= CNT_W'(SLEEP_ENTRY_CYC);
					end
				end
				DPD_SLEEP: begin
					if (wakeByReset) begin
						timer_q <= CNT_W'(RESET_CYC);
					end else if (wakeGo) begin
						timer_q <= CNT_W'(SLEEP_EXIT_CYC);
					end
				end
				DPD_ENTERING, DPD_EXITING, DPD_RESETTING: begin
					if (!timerDone(timer_q)) begin
						timer_q <= timer_q - CNT_W'(1);
					end
				end
				default: begin
					timer_q <= '0;
				end
			endcase
		end
	end

	// one-cycle pulse as the reset pair's delay runs out
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			featureReset <= 1'b0;
		end else begin
			featureReset <= (state_q == DPD_RESETTING) && timerDone(timer_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cmdAccept <= 1'b1;
		end else begin
			cmdAccept <= (state_q == DPD_STANDBY);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status <= '0;
		end else begin
			status.sleeping <= (state_q == DPD_SLEEP) || (state_q == DPD_ENTERING);
			status.busyExit <= (state_q == DPD_EXITING) || (state_q == DPD_RESETTING);
			status.featureReset <= featureReset;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/dpd_pkg.sv */
`default_nettype none
package dpd_pkg;
	localparam logic [7:0] CMD_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_RELEASE = 8'hab;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hff;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET = 8'h99;
	localparam int CLK_MHZ = 125;
	// entry and exit delays are not printed here; plain defaults in ns
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int SLEEP_EXIT_DELAY_NS = 3000;
	localparam int POWER_UP_SELECT_DELAY_MS = 2;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int POWER_UP_SELECT_CYC = POWER_UP_SELECT_DELAY_MS * CLK_MHZ * 1000;
	localparam int CNT_W = 20;
	typedef enum logic [2:0] {
		DPD_STANDBY = 3'h0,
		DPD_ENTERING = 3'h1,
		DPD_SLEEP = 3'h2,
		DPD_EXITING = 3'h3,
		DPD_RESETTING = 3'h4
	} dpd_state_e;
	typedef struct packed {
		logic sleeping;
		logic busyExit;
		logic featureReset;
	} dpd_status_s;
endpackage
`default_nettype wire

/* File: dv/dpd_properties.sv */
`default_nettype none
module dpd_properties (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic csN,
	input wire logic opInProgress,
	input wire logic cmdAccept,
	input wire logic featureReset,
	input wire dpd_pkg::dpd_status_s status
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	sequence s_pulse;
		featureReset ##1 !featureReset && status.featureReset;
	endsequence
	a_sleep_blocks: assert property (status.sleeping |-> !cmdAccept) else $error("asleep");
	a_exit_blocks: assert property (status.busyExit |-> !cmdAccept) else $error("exiting");
	a_sleep_deselect: assert property ($rose(status.sleeping) |-> csN) else $error("selected");
	a_sleep_idle: assert property ($rose(status.sleeping) |-> !$past(opInProgress, 2)) else $error("busy");
	a_exit_span: assert property ($rose(status.busyExit) |-> status.busyExit[*8]) else $error("short");
	a_pulse_once: assert property (featureReset |-> s_pulse) else $error("pulse");
	a_pulse_cause: assert property ($rose(featureReset) |-> $past(status.busyExit)) else $error("cause");
	a_reset_standby: assert property ($past(srst) |-> cmdAccept && status == '0) else $error("standby");
endmodule
bind dpd_deep_power_down_control dpd_properties i_dpd_properties(.clk_sys, .srst, .csN, .opInProgress, .cmdAccept,
	.featureReset, .status);
`default_nettype wire

/* File: dv/dpd_host.sv */
`default_nettype none
module dpd_host (
	input wire logic clk_sys,
	output logic csN,
	output logic sclk,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		csN = 1'h1;
		sclk = 1'h0;
		mosi = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// x adds a ninth bit, which must spoil the frame
	task automatic send(input logic [7:0] op, input bit x);
		tick(1);
		csN = 1'h0;
		for (int i = 0; i < 8 + x; i++) begin
			mosi = i < 8 ? op[7 - i] : 1'h0;
			tick(3);
			sclk = 1'h1;
			tick(3);
			sclk = 1'h0;
		end
		tick(3);
		csN = 1'h1;
		mosi = ~mosi; // no stale bit
		tick(12);
	endtask
endmodule
`default_nettype wire

/* File: dv/dpd_deep_power_down_control_bench.sv */
`default_nettype none
module dpd_deep_power_down_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dpd_pkg::*;
	logic clk_sys = 1'h0, srst = 1'h1, opInProgress = 1'h0, cmdAccept, featureReset, csN, sclk, mosi;
	dpd_status_s status;
	int failures = 0, checks_done = 0, cyc = 0, pulses = 0;
	always #4 clk_sys = ~clk_sys;
	dpd_host h(.clk_sys, .csN, .sclk, .mosi);
	// reset delay long enough that the check after the reset frame still sees it running
	dpd_deep_power_down_control #(.RESET_CYC(200)) i_dpd_deep_power_down_control(.clk_sys, .srst, .csN, .sclk, .mosi,
		.opInProgress, .cmdAccept, .featureReset, .status);
	always @(negedge clk_sys) begin
		if (featureReset === 1'h1)
			pulses++;
	end
	task automatic finish_test();
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 9000) begin
			failures++;
			finish_test();
		end
	end
	// e is {busyExit, sleeping, cmdAccept}
	task automatic sc(input logic [7:0] op, input bit x, input logic [2:0] e);
		h.send(op, x);
		checks_done++;
		if ({status.busyExit, status.sleeping, cmdAccept} !== e) begin
			failures++;
			$display("[ERR] mode %h exp %b got %b", op, e, {status.busyExit, status.sleeping, cmdAccept});
		end
	endtask
	task automatic t_reject();
		sc(8'h06, 0, 3'h1);
		sc(CMD_SLEEP, 1, 3'h1);
		opInProgress = 1'h1;
		sc(CMD_SLEEP, 0, 3'h1);
		opInProgress = 1'h0;
		sc(CMD_RELEASE, 0, 3'h1);
	endtask
	task automatic t_wake(input logic [7:0] pre, input logic [7:0] w, input bit busy, input int np);
		sc(CMD_SLEEP, 0, 3'h2);
		h.tick(400);
		opInProgress = busy;
		sc(pre, 0, 3'h2);
		opInProgress = 1'h0;
		sc(w, 0, 3'h4);
		h.tick(400);
		sc(8'h06, 0, 3'h1);
		checks_done++;
		if (pulses !== np) begin
			failures++;
			$display("[ERR] featureReset pulses exp %0d got %0d", np, pulses);
		end
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		srst = 1'h0;
		h.tick(4);
		t_reject();
		t_wake(8'h06, CMD_RELEASE, 0, 0);
		t_wake(8'h06, CMD_SOFT_RESET, 0, 0);
		t_wake(CMD_RELEASE, CMD_RELEASE, 1, 0);
		t_wake(CMD_RESET_ENABLE, CMD_RESET, 0, 1);
		finish_test();
	end
endmodule
`default_nettype wire
